// [jls_lane_src.sv]
// Behavioural lane receiver front end that feeds error strobes and sync levels
`timescale 1ns/1ps
`include "jls_params.svh"

module jls_lane_src
  import jls_pkg::*;
(
  input  wire logic                                pclk,
  output jls_err_t  [2*`JLS_LANES-1:0]             lane_err,
  output jls_sync_t [2*`JLS_LANES-1:0]             lane_sync
);
  initial begin
    lane_err  = '0;
    lane_sync = '0;
  end

  // ---------------------------------------------------------------------------
  // Error bursts: one strobe per cycle, k picks the counter (2 disparity)
  // ---------------------------------------------------------------------------
  task automatic burst(input int g, input int k, input int n);
    repeat (n) begin
      @(posedge pclk);
      lane_err[g][k] <= 1'b1;
    end
    @(posedge pclk);
    lane_err[g] <= '0;
    // Flag settles one edge after the counter, so let both land
    repeat (2) @(posedge pclk);
  endtask

  task automatic set_sync(input int g, input jls_sync_t s);
    @(posedge pclk);
    lane_sync[g] <= s;
  endtask
endmodule // jls_lane_src

// [jls_lane_status.sv]
// Lane 6 and lane 7 receive status registers with error counters, APB slave and interrupt
//
// Behaviour
// RQ1 - Bit 7 of lane_status_seven is 1 while the lane 7 bad disparity count is at or above the threshold.
// RQ2 - Bit 6 of lane_status_six is 1 while the lane 6 not-in-table count has reached the threshold.
// RQ3 - Bit 5 of lane_status_six is 1 while the lane 6 unexpected control character count is at or above the threshold.
// RQ4 - Each error flag compares its 8-bit count with error_count_threshold: 0 below it, 1 when equal or greater.
// RQ5 - Bit 4 of lane_status_six shows lane 6 interlane alignment, 1 aligned and 0 failed.
// RQ6 - Bit 3 of lane_status_six shows lane 6 initial lane sequence sync, 1 achieved and 0 lost.
// RQ7 - Bit 2 of lane_status_six shows whether the lane 6 configuration checksum matched, 1 correct.
// RQ8 - Bit 1 of lane_status_six shows lane 6 frame lock, 1 achieved and 0 lost.
// RQ9 - Bit 0 of lane_status_six shows lane 6 code group lock, 1 achieved and 0 lost.
// RQ10 - Every lane status field returns the link chosen by the link-select register at index 0x300.
// RQ11 - lane_status_seven has the lane 6 layout, with not-in-table on bit 6 and stray control on bit 5.
// RQ12 - Bit 4 of lane_status_seven shows lane 7 interlane alignment, 1 aligned and 0 failed.
// RQ13 - Bit 7 of lane_status_six at index 0x4B6 shows the lane 6 bad disparity count at the threshold.
// RQ14 - Both status registers are read-only, reset to zero and ignore writes.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "jls_params.svh"

module jls_lane_status
  import jls_pkg::*;
#(
  parameter int NUM_LINKS = 2,
  parameter int PAGE_W    = 1
) (
  input  wire logic                                 pclk,
  input  wire logic                                 presetn,
  input  wire logic                                 psel,
  input  wire logic                                 penable,
  input  wire logic                                 pwrite,
  input  wire logic [15:0]                          paddr,
  input  wire logic [31:0]                          pwdata,
  input  wire logic [3:0]                           pstrb,
  output logic      [31:0]                          prdata,
  output logic                                      pready,
  output logic                                      pslverr,
  output logic                                      irq,
  input  wire jls_err_t  [NUM_LINKS*`JLS_LANES-1:0] lane_err,
  input  wire jls_sync_t [NUM_LINKS*`JLS_LANES-1:0] lane_sync
);

  localparam int NG = NUM_LINKS * `JLS_LANES;

  // --------------------------------------------------------------------------
  // Decode helpers
  // --------------------------------------------------------------------------
  function automatic logic reg_known(input logic [13:0] idx);
    reg_known = (idx == `JLS_IDX_PAGE) || (idx == `JLS_IDX_SIX) || (idx == `JLS_IDX_SEVEN) ||
                (idx == `JLS_IDX_THRESH) || (idx == `JLS_IDX_CNT_CLR) ||
                (idx == `JLS_IDX_IRQ_STAT) || (idx == `JLS_IDX_IRQ_MASK);
  endfunction

  function automatic logic at_threshold(input logic [7:0] count, input logic [7:0] limit);
    at_threshold = (count >= limit);
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic [13:0]          idx;
  logic                 access;
  logic                 wr_commit;
  logic [PAGE_W-1:0]    page;
  logic [7:0]           thr;
  logic [7:0]           irq_status;
  logic [7:0]           irq_mask;
  logic [7:0]           irq_evt;
  logic [7:0]           next_irq_status;
  logic [7:0]           next_irq_mask;
  logic [7:0]           w1c;
  logic                 clr_strobe;
  logic [31:0]          next_prdata;
  logic [7:0]           err_cnt    [NG][`JLS_ERR_TYPES];
  jls_err_t             next_flags [NG];
  jls_lane_t            status_q   [NG];
  jls_lane_t            cur_six;
  jls_lane_t            cur_seven;

  assign idx        = paddr[15:2];
  assign access     = psel && penable && !pready;
  // A write lands only at the edge where the master sees pready high
  assign wr_commit  = psel && penable && pready && pwrite && pstrb[0];
  assign clr_strobe = wr_commit && (idx == `JLS_IDX_CNT_CLR) && pwdata[`JLS_CNT_CLR_BIT];
  assign w1c        = (wr_commit && (idx == `JLS_IDX_IRQ_STAT)) ? pwdata[7:0] : 8'h00;

  // --------------------------------------------------------------------------
  // APB handshake: one wait state, answer from flops
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready <= access;
      if (access) begin
        pslverr <= !reg_known(idx);
        prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Software-written controls
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page     <= '0;
      thr      <= `JLS_THRESH_RST;
      irq_mask <= `JLS_IRQ_RST;
    end else if (wr_commit) begin
      if (idx == `JLS_IDX_PAGE) begin
        page <= pwdata[PAGE_W-1:0];
      end
      if (idx == `JLS_IDX_THRESH) begin
        thr <= pwdata[7:0];
      end
      if (idx == `JLS_IDX_IRQ_MASK) begin
        irq_mask <= pwdata[7:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Paged view of the two status registers
  // --------------------------------------------------------------------------
  always_comb begin
    cur_six   = `JLS_STATUS_RST;
    cur_seven = `JLS_STATUS_RST;
    // A page beyond the last link reads as zero rather than aliasing
    for (int k = 0; k < NUM_LINKS; k++) begin
      if (page == PAGE_W'(k)) begin
        cur_six   = status_q[k*`JLS_LANES];     // RQ10
        cur_seven = status_q[k*`JLS_LANES + 1]; // RQ10
      end
    end
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    case (idx)
      `JLS_IDX_PAGE:     next_prdata = {{(32-PAGE_W){1'b0}}, page};
      `JLS_IDX_SIX:      next_prdata = {24'h00_0000, cur_six};   // RQ13
      `JLS_IDX_SEVEN:    next_prdata = {24'h00_0000, cur_seven}; // RQ11
      `JLS_IDX_THRESH:   next_prdata = {24'h00_0000, thr};
      `JLS_IDX_IRQ_STAT: next_prdata = {24'h00_0000, irq_status};
      `JLS_IDX_IRQ_MASK: next_prdata = {24'h00_0000, irq_mask};
      default:           next_prdata = 32'h0000_0000;
    endcase
  end

  // --------------------------------------------------------------------------
  // Error counters, flags and lane status, one set per link and lane
  // --------------------------------------------------------------------------
  genvar g, t;
  generate
    for (g = 0; g < NG; g++) begin : gen_lane
      for (t = 0; t < `JLS_ERR_TYPES; t++) begin : gen_cnt
        // Saturating, so a flood of errors never wraps below the threshold
        always_ff @(posedge pclk or negedge presetn) begin
          if (!presetn) begin
            err_cnt[g][t] <= 8'h00;
          end else if (clr_strobe && (page == PAGE_W'(g / `JLS_LANES))) begin
            err_cnt[g][t] <= lane_err[g][t] ? 8'h01 : 8'h00;
          end else if (lane_err[g][t] && (err_cnt[g][t] != `JLS_CNT_MAX)) begin
            err_cnt[g][t] <= err_cnt[g][t] + 8'h01;
          end
        end

        assign next_flags[g][t] = at_threshold(err_cnt[g][t], thr); // RQ4
      end

      // Status bits are read-only: no write path reaches them
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          status_q[g] <= `JLS_STATUS_RST; // RQ14
        end else begin
          status_q[g].flags <= next_flags[g]; // RQ1 RQ2 RQ3 RQ11 RQ13
          status_q[g].sync  <= lane_sync[g];  // RQ5 RQ6 RQ7 RQ8 RQ9 RQ12
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Interrupt: flags reaching the threshold and lock loss, any link
  // --------------------------------------------------------------------------
  always_comb begin
    irq_evt = 8'h00;
    for (int k = 0; k < NG; k++) begin
      for (int e = 0; e < `JLS_ERR_TYPES; e++) begin
        if (next_flags[k][e] && !status_q[k].flags[e]) begin
          irq_evt[`JLS_IRQ_ERR_BASE + (k % `JLS_LANES) * `JLS_ERR_TYPES + e] = 1'b1;
        end
      end
      if ((status_q[k].sync.frame_locked && !lane_sync[k].frame_locked) ||
          (status_q[k].sync.symbol_locked && !lane_sync[k].symbol_locked)) begin
        irq_evt[`JLS_IRQ_LOSS_BASE + (k % `JLS_LANES)] = 1'b1;
      end
    end
  end

  // A new event in the clearing cycle survives the clear
  assign next_irq_status = (irq_status & ~w1c) | irq_evt;
  // Mask and status land together, so irq never lags a mask write by a cycle
  assign next_irq_mask   = (wr_commit && (idx == `JLS_IDX_IRQ_MASK)) ? pwdata[7:0] : irq_mask;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= `JLS_IRQ_RST;
      irq        <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq        <= |(next_irq_status & next_irq_mask);
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_read_six;
    psel && penable && !pready && !pwrite && (idx == `JLS_IDX_SIX);
  endsequence

  sequence s_read_seven;
    psel && penable && !pready && !pwrite && (idx == `JLS_IDX_SEVEN);
  endsequence

  sequence s_cnt_past;
    (err_cnt[1][2] >= thr);
  endsequence

  chk_l7_disparity_flag: assert property (s_cnt_past |=> status_q[1].flags.disparity) // RQ1
    else $error("lane 7 disparity flag low at threshold");

  chk_l6_bad_code_flag: assert property ((err_cnt[0][1] < thr) && $stable(thr) ##1 $stable(err_cnt[0][1])
                                         |-> !status_q[0].flags.bad_code) // RQ2
    else $error("lane 6 not-in-table flag high below threshold");

  chk_l6_stray_flag: assert property (##1 status_q[0].flags.stray_control == $past(err_cnt[0][0] >= thr)) // RQ3
    else $error("lane 6 stray control flag wrong");

  chk_count_saturates: assert property ((err_cnt[0][2] == `JLS_CNT_MAX) && !clr_strobe
                                        |=> err_cnt[0][2] == `JLS_CNT_MAX) // RQ4
    else $error("error counter wrapped");

  chk_six_sync_bits: assert property (##1 status_q[0].sync == $past(lane_sync[0])) // RQ5 RQ6 RQ7 RQ8 RQ9
    else $error("lane 6 sync bits do not follow receiver");

  chk_l7_align_bit: assert property ($rose(lane_sync[1].align_ok) |=> status_q[1].sync.align_ok) // RQ12
    else $error("lane 7 alignment bit missed");

  chk_page_six_read: assert property (s_read_six |=> pready && (prdata[7:0] == $past(cur_six))
                                      && (prdata[31:8] == 24'h00_0000)) // RQ10 RQ13
    else $error("lane_status_six read returned wrong page");

  chk_page_seven_read: assert property (s_read_seven ##1 pready |-> prdata[7:0] == $past(cur_seven)) // RQ10 RQ11
    else $error("lane_status_seven read returned wrong page");

  chk_status_ro_write: assert property (wr_commit && ((idx == `JLS_IDX_SIX) || (idx == `JLS_IDX_SEVEN))
                                        |=> $stable(page) && $stable(thr) && $stable(irq_mask)) // RQ14
    else $error("write to status register changed a control");

  chk_irq_level: assert property (irq == |(irq_status & irq_mask))
    else $error("interrupt output does not match masked status");

  chk_answer_time: assert property ($rose(psel && penable) |-> !pready ##1 pready)
    else $error("slave answer not one wait state");

  sequence s_irq_clear;
    wr_commit && (idx == `JLS_IDX_IRQ_STAT);
  endsequence

  sequence s_clear_link0;
    clr_strobe && (page == PAGE_W'(0));
  endsequence

  chk_l6_disparity_flag: assert property (##1 status_q[0].flags.disparity == $past(err_cnt[0][2] >= thr)) // RQ13
    else $error("lane 6 disparity flag wrong");

  chk_l7_bad_code: assert property (##1 status_q[1].flags.bad_code == $past(err_cnt[1][1] >= thr)) // RQ11
    else $error("lane 7 not-in-table flag wrong");

  chk_l7_stray_flag: assert property (##1 status_q[1].flags.stray_control == $past(err_cnt[1][0] >= thr)) // RQ11
    else $error("lane 7 stray control flag wrong");

  chk_l7_sync_bits: assert property (##1 status_q[1].sync == $past(lane_sync[1])) // RQ12
    else $error("lane 7 sync bits do not follow receiver");

  chk_count_step: assert property (lane_err[0][2] && !clr_strobe && (err_cnt[0][2] != `JLS_CNT_MAX) // RQ4
                                   |=> err_cnt[0][2] == $past(err_cnt[0][2]) + 8'h01)
    else $error("error counter missed a strobe");

  chk_count_hold: assert property (!lane_err[0][2] && !clr_strobe |=> $stable(err_cnt[0][2])) // RQ4
    else $error("error counter moved without a strobe");

  chk_count_clear: assert property (s_clear_link0
                                    |=> err_cnt[0][0] == ($past(lane_err[0][0]) ? 8'h01 : 8'h00))
    else $error("counter clear left a stale count");

  chk_irq_set_wins: assert property (irq_evt[2] |=> irq_status[2])
    else $error("flag event lost to a clear");

  chk_irq_one_clears: assert property (s_irq_clear ##0 (irq_evt == 8'h00)
                                       |=> (irq_status & $past(pwdata[7:0])) == 8'h00)
    else $error("written one did not clear status");

  chk_lock_loss_event: assert property ($fell(lane_sync[0].frame_locked) |=> irq_status[`JLS_IRQ_LOSS_BASE])
    else $error("lane 6 frame lock loss not recorded");

  chk_unmapped_error: assert property (access && !reg_known(idx)
                                       |=> pready && pslverr && (prdata == 32'h0000_0000))
    else $error("unmapped access not refused");

  chk_mapped_no_error: assert property (access && reg_known(idx) |=> !pslverr)
    else $error("mapped access flagged as error");

  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held for more than one cycle");

  chk_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");

  chk_thresh_write: assert property (wr_commit && (idx == `JLS_IDX_THRESH) // RQ4
                                     |=> thr == $past(pwdata[7:0]))
    else $error("threshold write did not land");

  chk_page_write: assert property (wr_commit && (idx == `JLS_IDX_PAGE) // RQ10
                                   |=> page == $past(pwdata[PAGE_W-1:0]))
    else $error("page write did not land");

  chk_mask_write: assert property (wr_commit && (idx == `JLS_IDX_IRQ_MASK)
                                   |=> irq_mask == $past(pwdata[7:0]))
    else $error("mask write did not land");

  chk_strobe_ignored: assert property (psel && penable && pready && pwrite && !pstrb[0]
                                       |=> $stable(thr) && $stable(page) && $stable(irq_mask))
    else $error("write without byte strobe took effect");

endmodule // jls_lane_status

// [jls_lane_status_tb_top.sv]
// Self-checking bench for the lane 6/7 status bank
`timescale 1ns/1ps
`include "jls_params.svh"

module jls_lane_status_tb_top
  import jls_pkg::*;
;
  localparam logic [15:0] A_PAGE  = {`JLS_IDX_PAGE, 2'b00};
  localparam logic [15:0] A_SIX   = {`JLS_IDX_SIX, 2'b00};
  localparam logic [15:0] A_SEVEN = {`JLS_IDX_SEVEN, 2'b00};
  localparam logic [15:0] A_THR   = {`JLS_IDX_THRESH, 2'b00};
  localparam logic [15:0] A_CLR   = {`JLS_IDX_CNT_CLR, 2'b00};
  localparam logic [15:0] A_IST   = {`JLS_IDX_IRQ_STAT, 2'b00};
  localparam logic [15:0] A_MSK   = {`JLS_IDX_IRQ_MASK, 2'b00};
  localparam logic [15:0] A_NONE  = {14'h0500, 2'b00};

  logic                      pclk;
  logic                      presetn;
  logic                      psel;
  logic                      penable;
  logic                      pwrite;
  logic [15:0]               paddr;
  logic [31:0]               pwdata;
  logic [3:0]                pstrb;
  logic [31:0]               prdata;
  logic                      pready;
  logic                      pslverr;
  logic                      irq;
  jls_err_t  [3:0]           lane_err;
  jls_sync_t [3:0]           lane_sync;
  int                        err_count;
  int                        comparisons;
  int                        cycles;
  logic [7:0]                e [2];
  logic [31:0]               rdv;
  logic                      erv;

  jls_lane_status u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .lane_err(lane_err), .lane_sync(lane_sync));
  jls_lane_src u_src (.pclk(pclk), .lane_err(lane_err), .lane_sync(lane_sync));

  // ---------------------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // APB master: request held until pready is seen high at a rising edge
  // ---------------------------------------------------------------------------
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(rdv, {24'h0, exp});
    chk(erv, 1'b0);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, 4'hF);
  endtask

  task automatic irq_is(input logic exp);
    @(posedge pclk);
    chk(irq, exp);
  endtask

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      close_out();
    end
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    presetn = 1'b0;
    err_count = 0;
    comparisons = 0;
    e = '{8'h00, 8'h00};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_SIX, 8'h00);
    rd(A_SEVEN, 8'h00);
    rd(A_THR, 8'hFF);
    wr(A_SIX, 8'hFF);
    wr(A_SEVEN, 8'hFF);
    rd(A_SIX, 8'h00);
    rd(A_SEVEN, 8'h00);
    // Walk a single sync bit across each lane; drops of symbol lock and frame lock raise events
    for (int g = 0; g < 2; g++) begin
      for (int b = 0; b < 5; b++) begin
        u_src.set_sync(g, jls_sync_t'(5'h01 << b));
        rd(g ? A_SEVEN : A_SIX, 8'h01 << b);
      end
      u_src.set_sync(g, '0);
    end
    rd(A_IST, 8'hC0);
    irq_is(1'b0);
    wr(A_MSK, 8'h40);
    irq_is(1'b1);
    wr(A_IST, 8'h40);
    irq_is(1'b0);
    rd(A_IST, 8'h80);
    wr(A_PAGE, 8'h01);
    rd(A_SIX, 8'h00);
    u_src.set_sync(2, '1);
    rd(A_SIX, 8'h1F);
    rd(A_SEVEN, 8'h00);
    wr(A_PAGE, 8'h00);
    rd(A_SIX, 8'h00);
    apb(1'b1, A_THR, 32'h3, 4'h0);
    rd(A_THR, 8'hFF);
    wr(A_THR, 8'h03);
    // Two errors sit below the threshold, the third reaches it
    for (int g = 0; g < 2; g++) begin
      for (int k = 0; k < 3; k++) begin
        u_src.burst(g, k, 2);
        rd(g ? A_SEVEN : A_SIX, e[g]);
        u_src.burst(g, k, 1);
        e[g] = e[g] | (8'h20 << k);
        rd(g ? A_SEVEN : A_SIX, e[g]);
      end
    end
    rd(A_IST, 8'hBF);
    wr(A_CLR, 8'h01);
    rd(A_SIX, 8'h00);
    rd(A_SEVEN, 8'h00);
    // A wrapping counter would fall back below the top threshold here
    wr(A_THR, 8'hFF);
    u_src.burst(0, 2, 256);
    rd(A_SIX, 8'h80);
    apb(1'b0, A_NONE, 32'h0, 4'h0);
    chk(erv, 1'b1);
    chk(rdv, 32'h0);
    close_out();
  end
endmodule // jls_lane_status_tb_top

// [jls_params.svh]
// Offsets, field positions, reset values and sizes of the lane 6/7 status bank
`ifndef JLS_PARAMS_SVH
`define JLS_PARAMS_SVH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define JLS_LANES          2
`define JLS_ERR_TYPES      3

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define JLS_IDX_PAGE       14'h0300
`define JLS_IDX_SIX        14'h04B6
`define JLS_IDX_SEVEN      14'h04B7
`define JLS_IDX_THRESH     14'h04C0
`define JLS_IDX_CNT_CLR    14'h04C1
`define JLS_IDX_IRQ_STAT   14'h04C2
`define JLS_IDX_IRQ_MASK   14'h04C3

// ----------------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------------
`define JLS_THRESH_RST     8'hFF
`define JLS_STATUS_RST     8'h00
`define JLS_IRQ_RST        8'h00
`define JLS_CNT_MAX        8'hFF

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define JLS_CNT_CLR_BIT    0
`define JLS_IRQ_ERR_BASE   0
`define JLS_IRQ_LOSS_BASE  6

`endif

// [jls_pkg.sv]
// Types shared by the lane 6/7 status bank
package jls_pkg;

  // --------------------------------------------------------------------------
  // Error event strobes of one lane, one bit per error counter
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic disparity;
    logic bad_code;
    logic stray_control;
  } jls_err_t;

  // --------------------------------------------------------------------------
  // Synchronisation levels of one lane
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic align_ok;
    logic initial_seq_ok;
    logic config_sum_ok;
    logic frame_locked;
    logic symbol_locked;
  } jls_sync_t;

  // --------------------------------------------------------------------------
  // One lane status register, bit 7 down to bit 0
  // --------------------------------------------------------------------------
  typedef struct packed {
    jls_err_t  flags;
    jls_sync_t sync;
  } jls_lane_t;

endpackage
